/* ssq_sequencer.sv */
module ssq_sequencer
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        servo_enable_in,
	input  wire logic        fwd_run_request,
	input  wire logic        rev_run_request,
	input  wire logic        estop_in,
	input  wire logic        fwd_travel_limit,
	input  wire logic        rev_travel_limit,
	input  wire logic        analog_speed_ref,
	input  wire logic [3:0]  control_mode_select,
	input  wire logic [3:0]  encoder_cable_setting,
	input  wire logic [3:0]  attached_cable_code,
	input  wire logic [3:0]  param_access_setting,
	input  wire logic [15:0] decel_time_setting,
	input  wire logic        io_param_wr,
	input  wire logic [15:0] io_param_wdata,
	input  wire logic        alarm_clear,
	output logic             gate_enable,
	output logic             dyn_brake,
	output logic             pos_lock,
	output logic             run_fwd,
	output logic             run_rev,
	output logic             decel_active,
	output logic [15:0]      decel_time,
	output logic             ready,
	output logic             speed_mode,
	output logic [7:0]       alarm_code,
	output logic             estop_alarm,
	output logic             encoder_powerup_fault,
	output logic [15:0]      io_param,
	output logic             io_wr_rejected,
	output ssq_pkg::ssq_mode_t mode
);

	// ============================================================
	// Decode.
	logic             alarm_r;
	logic             powerup_done_r;
	logic             fwd_block_r;
	logic             rev_block_r;
	logic             servo_on;
	logic             one_req;
	logic             req_fwd_ok;
	logic             req_rev_ok;
	logic             enc_bad;
	logic             io_ok;
	ssq_pkg::ssq_mode_t mode_nxt;

	assign servo_on   = servo_enable_in && estop_in && !alarm_r && speed_mode;
	assign one_req    = fwd_run_request ^ rev_run_request;
	// A limit input low blocks only its own direction, so backing out stays legal.
	assign req_fwd_ok = fwd_run_request && fwd_travel_limit;
	assign req_rev_ok = rev_run_request && rev_travel_limit;
	assign enc_bad    = encoder_cable_setting != attached_cable_code;
	assign io_ok      = param_access_setting == ssq_pkg::SSQ_ACCESS_IO;

	// The first branch that matches wins, which sets the stop priority.
	always_comb
	begin
		if (!estop_in || alarm_r)
			mode_nxt = ssq_pkg::SSQ_DB_STOP;
		else if (!servo_enable_in || !speed_mode)
			mode_nxt = ssq_pkg::SSQ_COAST;
		else if ((fwd_run_request && !fwd_travel_limit) || (rev_run_request && !rev_travel_limit))
			mode_nxt = ssq_pkg::SSQ_LOCK;
		else if (!one_req || !analog_speed_ref)
			mode_nxt = ssq_pkg::SSQ_DECEL;
		else if (servo_on && req_fwd_ok)
			mode_nxt = ssq_pkg::SSQ_RUN_FWD;
		else if (servo_on && req_rev_ok)
			mode_nxt = ssq_pkg::SSQ_RUN_REV;
		else
			mode_nxt = ssq_pkg::SSQ_DECEL;
	end

	// ============================================================
	// Alarms.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alarm_r               <= 1'b0;
			alarm_code            <= ssq_pkg::SSQ_ALM_NONE;
			estop_alarm           <= 1'b0;
			encoder_powerup_fault <= 1'b0;
			powerup_done_r        <= 1'b0;
		end
		else
		begin
			powerup_done_r <= 1'b1;
			// The cable check runs once, on the first edge after reset release.
			if (!powerup_done_r && enc_bad)
			begin
				alarm_r               <= 1'b1;
				encoder_powerup_fault <= 1'b1;
				alarm_code            <= ssq_pkg::SSQ_ALM_ENCODER;
			end
			else if (!estop_in)
			begin
				alarm_r     <= 1'b1;
				estop_alarm <= 1'b1;
				alarm_code  <= ssq_pkg::SSQ_ALM_ESTOP;
			end
			else if (alarm_clear)
			begin
				alarm_r               <= 1'b0;
				estop_alarm           <= 1'b0;
				encoder_powerup_fault <= 1'b0;
				alarm_code            <= ssq_pkg::SSQ_ALM_NONE;
			end
		end
	end

	// ============================================================
	// Settings.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			speed_mode     <= 1'b0;
			io_param       <= ssq_pkg::SSQ_IO_RESET;
			io_wr_rejected <= 1'b0;
		end
		else
		begin
			speed_mode     <= control_mode_select == ssq_pkg::SSQ_MODE_SPEED;
			io_wr_rejected <= io_param_wr && !io_ok;
			if (io_param_wr && io_ok)
				io_param <= io_param_wdata;
		end
	end

	// ============================================================
	// Stop and run outputs.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode         <= ssq_pkg::SSQ_IDLE;
			gate_enable  <= 1'b0;
			dyn_brake    <= 1'b0;
			pos_lock     <= 1'b0;
			run_fwd      <= 1'b0;
			run_rev      <= 1'b0;
			decel_active <= 1'b0;
			decel_time   <= ssq_pkg::SSQ_DECEL_RESET;
			ready        <= 1'b0;
		end
		else
		begin
			mode         <= mode_nxt;
			ready        <= servo_on;
			gate_enable  <= mode_nxt inside {ssq_pkg::SSQ_LOCK, ssq_pkg::SSQ_DECEL,
				ssq_pkg::SSQ_RUN_FWD, ssq_pkg::SSQ_RUN_REV};
			dyn_brake    <= mode_nxt == ssq_pkg::SSQ_DB_STOP;
			pos_lock     <= mode_nxt == ssq_pkg::SSQ_LOCK;
			run_fwd      <= mode_nxt == ssq_pkg::SSQ_RUN_FWD;
			run_rev      <= mode_nxt == ssq_pkg::SSQ_RUN_REV;
			decel_active <= mode_nxt inside {ssq_pkg::SSQ_LOCK, ssq_pkg::SSQ_DECEL,
				ssq_pkg::SSQ_DB_STOP};
			decel_time   <= (mode_nxt == ssq_pkg::SSQ_DECEL) ? decel_time_setting
				: ssq_pkg::SSQ_DECEL_ZERO;
		end
	end

	// ============================================================
	// Checks.
	property p_coast;
		@(posedge clk) disable iff (!arst_n)
		(estop_in && !alarm_r && !servo_enable_in) |=> (!gate_enable && !dyn_brake);
	endproperty
	a_coast: assert property (p_coast) else $error("coast stop drove gate or brake");

	property p_alarm_brake;
		@(posedge clk) disable iff (!arst_n)
		alarm_r |=> (dyn_brake && !gate_enable);
	endproperty
	a_alarm_brake: assert property (p_alarm_brake) else $error("alarm without brake");

	property p_estop;
		@(posedge clk) disable iff (!arst_n)
		(!estop_in && powerup_done_r) |=> (dyn_brake && estop_alarm && alarm_code == ssq_pkg::SSQ_ALM_ESTOP);
	endproperty
	a_estop: assert property (p_estop) else $error("estop did not brake and alarm");

	property p_limit_lock;
		@(posedge clk) disable iff (!arst_n)
		(estop_in && !alarm_r && servo_enable_in && speed_mode && fwd_run_request && !fwd_travel_limit)
		|=> (pos_lock && gate_enable && decel_time == ssq_pkg::SSQ_DECEL_ZERO);
	endproperty
	a_limit_lock: assert property (p_limit_lock) else $error("limit did not lock");

	property p_back_out;
		@(posedge clk) disable iff (!arst_n)
		(servo_on && analog_speed_ref && rev_run_request && !fwd_run_request && !fwd_travel_limit
			&& rev_travel_limit) |=> run_rev;
	endproperty
	a_back_out: assert property (p_back_out) else $error("reverse refused at forward limit");

	property p_both_decel;
		@(posedge clk) disable iff (!arst_n)
		(servo_on && fwd_travel_limit && rev_travel_limit && !one_req)
		|=> (mode == ssq_pkg::SSQ_DECEL && !run_fwd && !run_rev);
	endproperty
	a_both_decel: assert property (p_both_decel) else $error("no ramp on equal requests");

	property p_zero_db;
		@(posedge clk) disable iff (!arst_n)
		dyn_brake |-> decel_time == ssq_pkg::SSQ_DECEL_ZERO;
	endproperty
	a_zero_db: assert property (p_zero_db) else $error("abrupt stop with ramp");

	property p_ready;
		@(posedge clk) disable iff (!arst_n)
		ready |-> $past(estop_in) && $past(servo_enable_in);
	endproperty
	a_ready: assert property (p_ready) else $error("ready without estop and enable");

	property p_run;
		@(posedge clk) disable iff (!arst_n)
		(run_fwd || run_rev) |-> $past(servo_on) && $past(analog_speed_ref) && $past(one_req);
	endproperty
	a_run: assert property (p_run) else $error("run without all conditions");

	property p_enc;
		@(posedge clk) disable iff (!arst_n)
		(!powerup_done_r && enc_bad) |=> encoder_powerup_fault ##1 dyn_brake;
	endproperty
	a_enc: assert property (p_enc) else $error("cable mismatch missed");

	property p_mode;
		@(posedge clk) disable iff (!arst_n)
		!speed_mode |=> !run_fwd && !run_rev;
	endproperty
	a_mode: assert property (p_mode) else $error("ran outside speed mode");

	property p_io;
		@(posedge clk) disable iff (!arst_n)
		(io_param_wr && !io_ok) |=> (io_wr_rejected && $stable(io_param));
	endproperty
	a_io: assert property (p_io) else $error("io write not rejected");

endmodule

/* ssq_pkg.sv */
package ssq_pkg;

	// ============================================================
	// Stop and run modes of the sequencer.
	typedef enum logic [2:0]
	{
		SSQ_IDLE,
		SSQ_COAST,
		SSQ_DB_STOP,
		SSQ_LOCK,
		SSQ_DECEL,
		SSQ_RUN_FWD,
		SSQ_RUN_REV
	} ssq_mode_t;

	// ============================================================
	// Setting encodings and reset values.
	localparam logic [3:0] SSQ_MODE_SPEED     = 4'h2;
	localparam logic [3:0] SSQ_CABLE_DEFAULT  = 4'h0;
	localparam logic [3:0] SSQ_ACCESS_DEFAULT = 4'h0;
	localparam logic [3:0] SSQ_ACCESS_IO      = 4'h1;
	localparam logic [7:0] SSQ_ALM_NONE       = 8'h00;
	localparam logic [7:0] SSQ_ALM_ESTOP      = 8'he6;
	localparam logic [7:0] SSQ_ALM_ENCODER    = 8'h16;
	localparam logic [15:0] SSQ_DECEL_ZERO    = 16'h0000;
	localparam logic [15:0] SSQ_DECEL_RESET   = 16'h0000;
	localparam logic [15:0] SSQ_IO_RESET      = 16'h0000;

endpackage

/* ssq_host_model.sv */
module ssq_host_model
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic want_on,
	input  wire logic want_fwd,
	input  wire logic want_rev,
	output logic      servo_enable_in,
	output logic      fwd_run_request,
	output logic      rev_run_request
);
	timeunit 1ns;
	timeprecision 1ns;

	// ============================================================
	// Command device
	// Requests follow the wish only while enabled, so enable always drops after them.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			servo_enable_in <= 1'b0;
			fwd_run_request <= 1'b0;
			rev_run_request <= 1'b0;
		end
		else
		begin
			fwd_run_request <= want_on && servo_enable_in && want_fwd;
			rev_run_request <= want_on && servo_enable_in && want_rev;
			servo_enable_in <= want_on || fwd_run_request || rev_run_request;
		end
	end
endmodule

/* tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ============================================================
	// Signals
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              want_on = 1'b0;
	logic [4:0]        mv = 5'h00;
	logic              estop_in = 1'b1;
	logic              io_param_wr = 1'b0, alarm_clear = 1'b0;
	logic [3:0]        control_mode_select = 4'h0, encoder_cable_setting = ssq_pkg::SSQ_CABLE_DEFAULT;
	logic [3:0]        attached_cable_code = 4'h3, param_access_setting = 4'h0;
	logic [15:0]       decel_time_setting = 16'h0000, io_param_wdata = 16'h0000;
	logic [31:0]       rs = 32'h21ed;
	int                n_errors = 0, checks_done = 0;
	wire logic         want_fwd, want_rev, fwd_travel_limit, rev_travel_limit, analog_speed_ref;
	wire logic         servo_enable_in, fwd_run_request, rev_run_request, gate_enable, dyn_brake, pos_lock;
	wire logic         run_fwd, run_rev, decel_active, ready, speed_mode, estop_alarm, encoder_powerup_fault;
	wire logic         io_wr_rejected;
	wire logic [15:0]  decel_time, io_param;
	wire logic [7:0]   alarm_code;
	wire ssq_pkg::ssq_mode_t mode;

	assign {want_fwd, want_rev, fwd_travel_limit, rev_travel_limit, analog_speed_ref} = mv;
	always #20 clk = ~clk;

	ssq_host_model host
	(
		.clk             (clk),
		.arst_n          (arst_n),
		.want_on         (want_on),
		.want_fwd        (want_fwd),
		.want_rev        (want_rev),
		.servo_enable_in (servo_enable_in),
		.fwd_run_request (fwd_run_request),
		.rev_run_request (rev_run_request)
	);

	ssq_sequencer dut
	(
		.clk                   (clk),
		.arst_n                (arst_n),
		.servo_enable_in       (servo_enable_in),
		.fwd_run_request       (fwd_run_request),
		.rev_run_request       (rev_run_request),
		.estop_in              (estop_in),
		.fwd_travel_limit      (fwd_travel_limit),
		.rev_travel_limit      (rev_travel_limit),
		.analog_speed_ref      (analog_speed_ref),
		.control_mode_select   (control_mode_select),
		.encoder_cable_setting (encoder_cable_setting),
		.attached_cable_code   (attached_cable_code),
		.param_access_setting  (param_access_setting),
		.decel_time_setting    (decel_time_setting),
		.io_param_wr           (io_param_wr),
		.io_param_wdata        (io_param_wdata),
		.alarm_clear           (alarm_clear),
		.gate_enable           (gate_enable),
		.dyn_brake             (dyn_brake),
		.pos_lock              (pos_lock),
		.run_fwd               (run_fwd),
		.run_rev               (run_rev),
		.decel_active          (decel_active),
		.decel_time            (decel_time),
		.ready                 (ready),
		.speed_mode            (speed_mode),
		.alarm_code            (alarm_code),
		.estop_alarm           (estop_alarm),
		.encoder_powerup_fault (encoder_powerup_fault),
		.io_param              (io_param),
		.io_wr_rejected        (io_wr_rejected),
		.mode                  (mode)
	);

	// ============================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected {pos_lock, decel_active, run_fwd, run_rev} for one request pattern.
	// A limit lock is an abrupt stop, so it counts as a deceleration as well.
	function automatic logic [3:0] exp_mv(input logic [4:0] m);
		if ((m[4] && !m[3] && !m[2]) || (m[3] && !m[4] && !m[1]))
			return 4'hc;
		if (m[4] == m[3] || !m[0])
			return 4'h4;
		return {2'b00, m[4], m[3]};
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic io_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		param_access_setting <= a;
		io_param_wdata <= d;
		io_param_wr <= 1'b1;
		@(posedge clk);
		io_param_wr <= 1'b0;
		#1;
		chk(io_wr_rejected, a != ssq_pkg::SSQ_ACCESS_IO);
		chk(io_param, (a == ssq_pkg::SSQ_ACCESS_IO) ? d : ssq_pkg::SSQ_IO_RESET);
	endtask

	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ============================================================
	// Watchdog
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		test_done;
	end

	// ============================================================
	// Tests
	initial
	begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		wt(3);
		chk({encoder_powerup_fault, alarm_code}, {1'b1, ssq_pkg::SSQ_ALM_ENCODER});
		chk({gate_enable, dyn_brake}, 2'b01);
		@(posedge clk);
		attached_cable_code <= ssq_pkg::SSQ_CABLE_DEFAULT;
		arst_n <= 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		wt(3);
		chk({encoder_powerup_fault, alarm_code}, 9'h000);
		$display("test encoder done");
		io_wr(ssq_pkg::SSQ_ACCESS_DEFAULT, 16'hbeef);
		io_wr(ssq_pkg::SSQ_ACCESS_IO, rs[15:0]);
		$display("test io access done");
		@(posedge clk);
		want_on <= 1'b1;
		mv <= 5'h17;
		wt(6);
		chk({speed_mode, gate_enable, run_fwd}, 3'b000);
		@(posedge clk);
		control_mode_select <= ssq_pkg::SSQ_MODE_SPEED;
		wt(4);
		chk({speed_mode, ready, gate_enable, run_fwd}, 4'hf);
		$display("test mode done");
		// Equal requests keep both limit inputs high (not reached) so lock and ramp never compete.
		repeat (40)
		begin
			rs = lfsr(rs);
			@(posedge clk);
			mv <= (rs[4] == rs[3]) ? (rs[4:0] | 5'h06) : rs[4:0];
			decel_time_setting <= rs[31:16];
			wt(4);
			chk({pos_lock, decel_active, run_fwd, run_rev}, exp_mv(mv));
			if (exp_mv(mv) == 4'h4)
				chk(decel_time, decel_time_setting);
			else
				chk(decel_time, ssq_pkg::SSQ_DECEL_ZERO);
			chk(ready, 1'b1);
		end
		$display("test random run done");
		@(posedge clk);
		mv <= 5'h13;
		estop_in <= 1'b0;
		wt(4);
		chk({dyn_brake, gate_enable, pos_lock, ready, estop_alarm}, 5'h11);
		chk(alarm_code, ssq_pkg::SSQ_ALM_ESTOP);
		chk(decel_time, ssq_pkg::SSQ_DECEL_ZERO);
		chk(mode, ssq_pkg::SSQ_DB_STOP);
		@(posedge clk);
		estop_in <= 1'b1;
		alarm_clear <= 1'b1;
		@(posedge clk);
		alarm_clear <= 1'b0;
		wt(4);
		chk({estop_alarm, alarm_code, pos_lock, ready}, 11'h003);
		$display("test estop done");
		@(posedge clk);
		want_on <= 1'b0;
		wt(6);
		chk({gate_enable, dyn_brake, ready, run_fwd}, 4'h0);
		chk(mode, ssq_pkg::SSQ_COAST);
		$display("test coast done");
		test_done;
	end
endmodule
